// *** include/axis_capture_map.svh ***
`ifndef AXIS_CAPTURE_MAP_SVH
`define AXIS_CAPTURE_MAP_SVH
// Register byte offsets
`define OFS_CAPTURE_CTRL   12'h000
`define OFS_CAPTURE_POS    12'h004
`define OFS_WINDOW_OPEN    12'h008
`define OFS_WINDOW_CLOSE   12'h00C
`define OFS_WRAP_DISTANCE  12'h010
`define OFS_WRAP_OPTION    12'h014
`define OFS_REV_LIMIT_SEL  12'h018
`define OFS_AXIS_STATE     12'h01C
`define OFS_MEASURED_POS   12'h020
`define OFS_DEMAND_POS     12'h024
`define OFS_POS_DEFINE     12'h028
// Mode field layout
`define MODE_TRIG_LSB      0
`define MODE_TRIG_MSB      7
`define MODE_WIN_LSB       8
`define MODE_WIN_MSB       9
`define WIN_NONE           2'h0
`define WIN_INCLUSIVE      2'h1
`define WIN_EXCLUSIVE      2'h3
`define TRIG_INDEX_RISE    8'h01
`define TRIG_INDEX_FALL    8'h02
`define TRIG_REG_RISE      8'h03
`define TRIG_REG_FALL      8'h04
// Wrap option bits
`define WRAP_POSITIVE_BIT  0
`define WRAP_END_REPEAT_BIT 1
// Axis state word bits
`define STATE_REV_LIMIT_BIT 5
`define STATE_CAPTURED_BIT  0
`define STATE_ARMED_BIT     1
`define STATE_REPEAT_BIT    2
// Reset values and valid selector ranges
`define REV_LIMIT_NONE     8'hFF
`define WRAP_DIST_RESET    32'h0000_0000
`define REV_SEL_LOW_MAX    8'h0F
`define REV_SEL_HIGH_MIN   8'h14
`define REV_SEL_HIGH_MAX   8'h1F
`endif

// *** include/axis_capture_pkg.sv ***
package axis_capture_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
endpackage : axis_capture_pkg

// *** design/axis_capture_and_wrap.sv ***
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "axis_capture_map.svh"

module axis_capture_and_wrap #(
  parameter int AXIS_INDEX = 0,   // Axis number, selects its registration input
  parameter int POS_W      = 32   // Position width
) (
  input  wire logic                     CLOCK,          // 125 MHz clock
  input  wire logic                     RST_N,          // Async reset, active low
  input  wire axis_capture_pkg::apb_req_t APB_REQ,      // APB request group
  output var  axis_capture_pkg::apb_rsp_t APB_RSP,      // APB answer group
  input  wire logic [POS_W-1:0]         MEASURED_IN,    // Raw measured position
  input  wire logic signed [POS_W-1:0]  DEMAND_STEP,    // Demand increment per cycle
  input  wire logic                     INDEX_MARKER,   // Encoder index marker
  input  wire logic [3:0]               REG_INPUTS,     // Registration inputs 0..3
  input  wire logic [31:0]              GP_INPUTS,      // General inputs for limit
  input  wire logic                     REPEAT_ENDED,   // Motion side ended repeat
  output logic                          CAPTURE_FLAG,   // Capture flag
  output logic                          REV_MOTION_STOP,// Block reverse motion
  output logic                          END_REPEAT_REQ  // Repeat end request level
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Fold a position into the active range
  function automatic logic signed [POS_W-1:0] fold(input logic signed [POS_W-1:0] p,
                                                   input logic signed [POS_W-1:0] d,
                                                   input logic                    pos_only);
    logic signed [POS_W-1:0] lo;
    lo = pos_only ? '0 : -d;
    if (d <= 0) begin
      fold = p;
    end else if (p >= d) begin
      fold = p - d;
    end else if (p < lo) begin
      fold = p + d;
    end else begin
      fold = p;
    end
  endfunction : fold

  // Selector holds a valid limit input
  function automatic logic sel_valid(input logic [7:0] s);
    sel_valid = (s <= `REV_SEL_LOW_MAX) ||
                (s >= `REV_SEL_HIGH_MIN && s <= `REV_SEL_HIGH_MAX);
  endfunction : sel_valid

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [9:0]              mode_q;
  logic                    armed_q;
  logic                    flag_q;
  logic signed [POS_W-1:0] cap_pos_q;
  logic signed [POS_W-1:0] open_q;
  logic signed [POS_W-1:0] close_q;
  logic signed [POS_W-1:0] dist_q;
  logic [1:0]              opt_q;
  logic [7:0]              rev_sel_q;
  logic signed [POS_W-1:0] offset_q;
  logic signed [POS_W-1:0] demand_q;
  logic                    index_prev_q;
  logic                    reg_prev_q;
  logic                    rev_hit_q;
  logic [31:0]             rdata_q;
  logic                    ready_q;
  logic                    err_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       setup    = APB_REQ.psel && !APB_REQ.penable;
  wire       wr_now   = APB_REQ.psel && APB_REQ.penable && ready_q && APB_REQ.pwrite;
  wire [11:0] addr    = APB_REQ.paddr;
  wire       wr_ctrl  = wr_now && addr == `OFS_CAPTURE_CTRL;
  wire       wr_open  = wr_now && addr == `OFS_WINDOW_OPEN;
  wire       wr_close = wr_now && addr == `OFS_WINDOW_CLOSE;
  wire       wr_dist  = wr_now && addr == `OFS_WRAP_DISTANCE;
  wire       wr_opt   = wr_now && addr == `OFS_WRAP_OPTION;
  wire       wr_sel   = wr_now && addr == `OFS_REV_LIMIT_SEL;
  wire       wr_def   = wr_now && addr == `OFS_POS_DEFINE;
  wire       wr_demand_position  = wr_now && addr == `OFS_DEMAND_POS;

  // ----------------------------------------------------------------
  // Position and wrap
  // ----------------------------------------------------------------
  // Measured position as the axis sees it, offset folds it into range
  wire signed [POS_W-1:0] meas_raw = $signed(MEASURED_IN) + offset_q;
  wire signed [POS_W-1:0] meas_fold = fold(meas_raw, dist_q, opt_q[`WRAP_POSITIVE_BIT]);
  wire signed [POS_W-1:0] wrap_adj  = meas_fold - meas_raw;
  wire signed [POS_W-1:0] wr_pos    = $signed(APB_REQ.pwdata[POS_W-1:0]);
  wire signed [POS_W-1:0] dem_next  = demand_q + DEMAND_STEP + wrap_adj;

  // ----------------------------------------------------------------
  // Capture trigger and window
  // ----------------------------------------------------------------
  wire       reg_in    = REG_INPUTS[AXIS_INDEX[1:0]];
  wire [7:0] trig      = mode_q[`MODE_TRIG_MSB:`MODE_TRIG_LSB];
  wire [1:0] win       = mode_q[`MODE_WIN_MSB:`MODE_WIN_LSB];
  wire       edge_hit  = (trig == `TRIG_INDEX_RISE && INDEX_MARKER && !index_prev_q) ||
                         (trig == `TRIG_INDEX_FALL && !INDEX_MARKER && index_prev_q) ||
                         (trig == `TRIG_REG_RISE && reg_in && !reg_prev_q) ||
                         (trig == `TRIG_REG_FALL && !reg_in && reg_prev_q);
  wire       in_incl   = meas_fold > open_q && meas_fold < close_q;
  wire       in_excl   = meas_fold < open_q || meas_fold > close_q;
  wire       win_ok    = (win == `WIN_INCLUSIVE) ? in_incl :
                         (win == `WIN_EXCLUSIVE) ? in_excl : 1'b1;
  wire       capture   = armed_q && edge_hit && win_ok;

  // Reverse limit select, active low
  wire       rev_level = sel_valid(rev_sel_q) && !GP_INPUTS[rev_sel_q[4:0]];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  wire  [31:0] state_word = {26'h0, rev_hit_q, 2'h0, opt_q[`WRAP_END_REPEAT_BIT],
                             armed_q, flag_q};
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr)
      `OFS_CAPTURE_CTRL:  rd_mux = {22'h0, mode_q};
      `OFS_CAPTURE_POS:   rd_mux = 32'(cap_pos_q);
      `OFS_WINDOW_OPEN:   rd_mux = 32'(open_q);
      `OFS_WINDOW_CLOSE:  rd_mux = 32'(close_q);
      `OFS_WRAP_DISTANCE: rd_mux = 32'(dist_q);
      `OFS_WRAP_OPTION:   rd_mux = {30'h0, opt_q};
      `OFS_REV_LIMIT_SEL: rd_mux = {24'h0, rev_sel_q};
      `OFS_AXIS_STATE:    rd_mux = state_word;
      `OFS_MEASURED_POS:  rd_mux = 32'(meas_fold);
      `OFS_DEMAND_POS:    rd_mux = 32'(demand_q);
      default:            rd_mux = 32'h0000_0000;
    endcase
  end
  wire addr_ok = addr inside {`OFS_CAPTURE_CTRL, `OFS_CAPTURE_POS, `OFS_WINDOW_OPEN,
                              `OFS_WINDOW_CLOSE, `OFS_WRAP_DISTANCE, `OFS_WRAP_OPTION,
                              `OFS_REV_LIMIT_SEL, `OFS_AXIS_STATE, `OFS_MEASURED_POS,
                              `OFS_DEMAND_POS, `OFS_POS_DEFINE};

  // ----------------------------------------------------------------
  // APB slave: no wait state, ready rises in the access phase
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      ready_q <= setup;
      rdata_q <= setup ? rd_mux : 32'h0000_0000;
      err_q   <= setup && !addr_ok;
    end
  end

  // ----------------------------------------------------------------
  // Capture arming, latch and flag
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q       <= 10'h000;
      armed_q      <= 1'b0;
      flag_q       <= 1'b0;
      cap_pos_q    <= '0;
      index_prev_q <= 1'b0;
      reg_prev_q   <= 1'b0;
    end else begin
      index_prev_q <= INDEX_MARKER;
      reg_prev_q   <= reg_in;
      if (capture) begin
        cap_pos_q <= meas_fold;
        flag_q    <= 1'b1;
        armed_q   <= 1'b0;
      end else if (wr_ctrl) begin
        mode_q  <= APB_REQ.pwdata[9:0];
        armed_q <= 1'b1;
        flag_q  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Window, wrap and limit settings
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      open_q    <= '0;
      close_q   <= '0;
      dist_q    <= POS_W'(`WRAP_DIST_RESET);
      rev_sel_q <= `REV_LIMIT_NONE;
    end else begin
      if (wr_open)  open_q    <= wr_pos;
      if (wr_close) close_q   <= wr_pos;
      if (wr_dist)  dist_q    <= wr_pos;
      if (wr_sel)   rev_sel_q <= APB_REQ.pwdata[7:0];
    end
  end

  // Option bits; a software set wins over the hardware clear
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      opt_q <= 2'h0;
    end else if (wr_opt) begin
      opt_q <= APB_REQ.pwdata[1:0];
    end else if (REPEAT_ENDED) begin
      opt_q[`WRAP_END_REPEAT_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Position offset and demand tracking
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      offset_q <= '0;
      demand_q <= '0;
    end else if (wr_def) begin
      offset_q <= fold(wr_pos, dist_q, opt_q[0]) - $signed(MEASURED_IN);
      demand_q <= fold(wr_pos, dist_q, opt_q[0]);
    end else if (wr_demand_position) begin
      offset_q <= offset_q + wrap_adj;
      demand_q <= fold(wr_pos, dist_q, opt_q[0]);
    end else begin
      offset_q <= offset_q + wrap_adj;
      demand_q <= dem_next;
    end
  end

  // Reverse limit status
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rev_hit_q <= 1'b0;
    end else begin
      rev_hit_q <= rev_level;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign APB_RSP.prdata  = rdata_q;
  assign APB_RSP.pready  = ready_q;
  assign APB_RSP.pslverr = err_q;
  assign CAPTURE_FLAG    = flag_q;
  assign REV_MOTION_STOP = rev_hit_q;
  assign END_REPEAT_REQ  = opt_q[`WRAP_END_REPEAT_BIT];

endmodule : axis_capture_and_wrap
`default_nettype wire

// *** tb/axis_capture_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "axis_capture_map.svh"
// ------------------------------
// Port checker
// ------------------------------
module axis_capture_monitor #(
  parameter int AXIS_INDEX = 0 // Axis number
) (
  input wire logic                       CLOCK,           // Clock
  input wire logic                       RST_N,           // Reset, active low
  input wire axis_capture_pkg::apb_req_t APB_REQ,         // Bus request
  input wire axis_capture_pkg::apb_rsp_t APB_RSP,         // Bus answer
  input wire logic                       INDEX_MARKER,    // Marker
  input wire logic [3:0]                 REG_INPUTS,      // Sensors
  input wire logic [31:0]                GP_INPUTS,       // Limit inputs
  input wire logic                       REPEAT_ENDED,    // Repeat ended
  input wire logic                       CAPTURE_FLAG,    // Flag
  input wire logic                       REV_MOTION_STOP, // Reverse stop
  input wire logic                       END_REPEAT_REQ   // End request
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Completed writes
  wire logic wr_done = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & APB_RSP.pready;
  wire logic ctl_wr  = wr_done & (APB_REQ.paddr == `OFS_CAPTURE_CTRL);
  wire logic opt_set = wr_done & (APB_REQ.paddr == `OFS_WRAP_OPTION) & APB_REQ.pwdata[1];
  logic [1:0] lvl_q;
  logic [2:0] chg_q;
  logic [1:0] ctl_q;
  logic [1:0] opt_q;
  // Short history of trigger changes and writes
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lvl_q <= 2'h0;
      chg_q <= 3'h0;
      ctl_q <= 2'h0;
      opt_q <= 2'h0;
    end else begin
      lvl_q <= {INDEX_MARKER, REG_INPUTS[AXIS_INDEX]};
      chg_q <= {chg_q[1:0], lvl_q != {INDEX_MARKER, REG_INPUTS[AXIS_INDEX]}};
      ctl_q <= {ctl_q[0], ctl_wr};
      opt_q <= {opt_q[0], opt_set};
    end
  end
  chk_ready_next: assert property (APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready)
    else $error("no answer after setup");
  chk_ready_pulse: assert property (APB_RSP.pready |=> !APB_RSP.pready)
    else $error("ready held too long");
  chk_err_zero: assert property (APB_RSP.pslverr |-> APB_RSP.pready && APB_RSP.prdata == 32'h0)
    else $error("error answer malformed");
  chk_flag_cause: assert property ($rose(CAPTURE_FLAG) |-> |chg_q)
    else $error("flag rose without trigger change");
  chk_flag_clear: assert property ($fell(CAPTURE_FLAG) |-> ctl_wr || |ctl_q)
    else $error("flag fell without arming write");
  chk_stop_cause: assert property ($rose(REV_MOTION_STOP) |-> !(&$past(GP_INPUTS)))
    else $error("stop without low input");
  chk_end_set: assert property ($rose(END_REPEAT_REQ) |-> opt_set || |opt_q)
    else $error("end request without write");
  chk_end_clear: assert property (REPEAT_ENDED && END_REPEAT_REQ && !APB_REQ.psel
    |-> ##[1:2] !END_REPEAT_REQ)
    else $error("end request not cleared");
endmodule : axis_capture_monitor
bind axis_capture_and_wrap axis_capture_monitor #(.AXIS_INDEX(AXIS_INDEX)) axis_capture_monitor_i (
  .CLOCK(CLOCK), .RST_N(RST_N), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
  .INDEX_MARKER(INDEX_MARKER), .REG_INPUTS(REG_INPUTS), .GP_INPUTS(GP_INPUTS),
  .REPEAT_ENDED(REPEAT_ENDED), .CAPTURE_FLAG(CAPTURE_FLAG),
  .REV_MOTION_STOP(REV_MOTION_STOP), .END_REPEAT_REQ(END_REPEAT_REQ));
`default_nettype wire

// *** tb/axis_sensor_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Encoder and sensor model
// ------------------------------
module axis_sensor_model #(
  parameter int LAG = 2 // Sensor delay in cycles, at least 2
) (
  input  wire logic        clk,     // Clock
  input  wire logic        rst_n,   // Reset, active low
  input  wire logic [31:0] target,  // Position to travel to
  input  wire logic        idx_lvl, // Wanted marker level
  input  wire logic        reg_lvl, // Wanted sensor level
  output logic [31:0]      pos,     // Encoder count
  output logic             idx,     // Marker line
  output logic [3:0]       regs     // Sensor lines
);
  logic [LAG-1:0] idx_sh;
  logic [LAG-1:0] reg_sh;
  // Travel one count per cycle, sensors answer late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos    <= 32'h0;
      idx_sh <= '0;
      reg_sh <= '0;
    end else begin
      if (pos != target) pos <= ($signed(target) > $signed(pos)) ? pos + 32'h1 : pos - 32'h1;
      idx_sh <= {idx_sh[LAG-2:0], idx_lvl};
      reg_sh <= {reg_sh[LAG-2:0], reg_lvl};
    end
  end
  // Other axes' sensors keep moving
  assign idx  = idx_sh[LAG-1];
  assign regs = {pos[2:0], reg_sh[LAG-1]};
endmodule : axis_sensor_model
`default_nettype wire

// *** tb/axis_capture_and_wrap_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "axis_capture_map.svh"
module axis_capture_and_wrap_tb;
  logic clk, rst_n, idx_lvl, reg_lvl, rep_end, idx, flag, stop, endreq;
  logic [31:0] tgt, pos, gp, q, dstep;
  logic [3:0] regs;
  logic e;
  axis_capture_pkg::apb_req_t req;
  axis_capture_pkg::apb_rsp_t rsp;
  int err_count = 0;
  int cmp_count = 0;
  axis_capture_and_wrap axis_capture_and_wrap_i (.CLOCK(clk), .RST_N(rst_n), .APB_REQ(req),
    .APB_RSP(rsp), .MEASURED_IN(pos), .DEMAND_STEP(dstep), .INDEX_MARKER(idx),
    .REG_INPUTS(regs), .GP_INPUTS(gp), .REPEAT_ENDED(rep_end), .CAPTURE_FLAG(flag),
    .REV_MOTION_STOP(stop), .END_REPEAT_REQ(endreq));
  axis_sensor_model axis_sensor_model_i (.clk(clk), .rst_n(rst_n), .target(tgt),
    .idx_lvl(idx_lvl), .reg_lvl(reg_lvl), .pos(pos), .idx(idx), .regs(regs));
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic hang;
    err_count++;
    $display("FAIL wait expected done seen timeout");
    close_out();
  endtask : hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) hang();
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, q);
  endtask : chk_rd
  task automatic go_to(input logic [31:0] t);
    int n;
    n = 0;
    tgt <= t;
    do begin
      @(posedge clk);
      n++;
    end while (pos !== t && n < 400);
    if (pos !== t) hang();
  endtask : go_to
  task automatic settle(input logic exp);
    int n;
    n = 0;
    repeat (exp ? 0 : 8) @(posedge clk);
    while (flag !== exp && n < 8) begin
      @(posedge clk);
      n++;
    end
    cmp("capture flag", {31'h0, exp}, {31'h0, flag});
  endtask : settle
  task automatic toggle(input logic on_idx);
    repeat (2) begin
      @(posedge clk);
      if (on_idx) idx_lvl <= !idx_lvl;
      else reg_lvl <= !reg_lvl;
      repeat (4) @(posedge clk);
    end
  endtask : toggle
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset;
    chk_rd(`OFS_REV_LIMIT_SEL, 32'hFF, "selector");
    chk_rd(`OFS_AXIS_STATE, 32'h0, "state");
    chk_rd(12'h03C, 32'h0, "unmapped data");
    cmp("unmapped error", 32'h1, {31'h0, e});
    $display("reset test done");
  endtask : t_reset
  task automatic t_modes;
    logic idle;
    logic on_idx;
    for (int m = 1; m <= 4; m++) begin
      idle = (m % 2 == 0);
      on_idx = (m <= 2);
      @(posedge clk);
      idx_lvl <= idle;
      reg_lvl <= idle;
      go_to(32'h64 * m);
      apb(1'b1, `OFS_CAPTURE_CTRL, 32'(m));
      toggle(!on_idx);
      settle(1'b0);
      if (on_idx) idx_lvl <= !idle;
      else reg_lvl <= !idle;
      settle(1'b1);
      chk_rd(`OFS_CAPTURE_POS, 32'h64 * m, "captured");
      go_to(32'h64 * m + 32'h7);
      toggle(on_idx);
      chk_rd(`OFS_CAPTURE_POS, 32'h64 * m, "held capture");
      chk_rd(`OFS_AXIS_STATE, 32'h1, "disarmed state");
    end
    $display("mode test done");
  endtask : t_modes
  task automatic t_window;
    logic [31:0] md [6] = '{32'h103, 32'h103, 32'h103, 32'h303, 32'h303, 32'h303};
    logic [31:0] ps [6] = '{32'h32, 32'h64, 32'h96, 32'h96, 32'hC8, 32'hFA};
    logic ok [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    apb(1'b1, `OFS_WINDOW_OPEN, 32'h64);
    apb(1'b1, `OFS_WINDOW_CLOSE, 32'hC8);
    for (int i = 0; i < 6; i++) begin
      reg_lvl <= 1'b0;
      go_to(ps[i]);
      apb(1'b1, `OFS_CAPTURE_CTRL, md[i]);
      repeat (4) @(posedge clk);
      reg_lvl <= 1'b1;
      settle(ok[i]);
    end
    $display("window test done");
  endtask : t_window
  task automatic t_wrap;
    apb(1'b1, `OFS_WRAP_DISTANCE, 32'h3E8);
    apb(1'b1, `OFS_WRAP_OPTION, 32'h1);
    apb(1'b1, `OFS_DEMAND_POS, 32'h5DC);
    chk_rd(`OFS_DEMAND_POS, 32'h1F4, "folded demand");
    apb(1'b1, `OFS_WRAP_OPTION, 32'h0);
    apb(1'b1, `OFS_DEMAND_POS, 32'hFFFF_FA24);
    chk_rd(`OFS_DEMAND_POS, 32'hFFFF_FE0C, "signed fold");
    // Measured position crosses the range end and drags demand along
    apb(1'b1, `OFS_WRAP_DISTANCE, 32'h12C);
    apb(1'b1, `OFS_DEMAND_POS, 32'h64);
    go_to(32'h136);
    chk_rd(`OFS_MEASURED_POS, 32'hA, "wrapped measured");
    chk_rd(`OFS_DEMAND_POS, 32'hFFFF_FF38, "wrapped demand");
    apb(1'b1, `OFS_POS_DEFINE, 32'h15E);
    chk_rd(`OFS_MEASURED_POS, 32'h32, "defined measured");
    // Demand alone leaves the range; no adjustment follows
    dstep <= 32'h100;
    repeat (2) @(posedge clk);
    dstep <= 32'h0;
    chk_rd(`OFS_DEMAND_POS, 32'h232, "demand outside range");
    apb(1'b1, `OFS_WRAP_DISTANCE, 32'h0);
    $display("wrap test done");
  endtask : t_wrap
  task automatic t_limit;
    apb(1'b1, `OFS_REV_LIMIT_SEL, 32'h14);
    gp[20] <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("reverse stop", 32'h1, {31'h0, stop});
    chk_rd(`OFS_AXIS_STATE, 32'h21, "limit state");
    apb(1'b1, `OFS_REV_LIMIT_SEL, 32'hFF);
    repeat (3) @(posedge clk);
    cmp("no limit", 32'h0, {31'h0, stop});
    gp <= 32'hFFFF_FFFF;
    apb(1'b1, `OFS_WRAP_OPTION, 32'h2);
    repeat (2) @(posedge clk);
    cmp("end request", 32'h1, {31'h0, endreq});
    rep_end <= 1'b1;
    @(posedge clk);
    rep_end <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("end request cleared", 32'h0, {31'h0, endreq});
    chk_rd(`OFS_WRAP_OPTION, 32'h0, "option cleared");
    $display("limit and repeat test done");
  endtask : t_limit
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, idx_lvl, reg_lvl, rep_end, req} = '0;
    tgt = 32'h0;
    dstep = 32'h0;
    gp = 32'hFFFF_FFFF;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_window();
    t_wrap();
    t_limit();
    close_out();
  end
endmodule : axis_capture_and_wrap_tb
`default_nettype wire
